/* File: tps_timer.sv */
// Timer prescaler, secondary oscillator control and 16-bit counter with APB registers
//
// The APB register port and the register offsets were chosen for this implementation.
`include "tps_map.svh"
`default_nettype none
module tps_timer (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic sleep_i,
	input wire logic crystal_in_pin_i,
	output logic crystal_amp_en_o,
	output logic overflow_flag_o
);

	tps_pkg::tps_apb_req_t req;
	tps_pkg::tps_ctrl_t timer_control_reg;
	logic [15:0] count;
	logic [2:0] psc;
	logic [2:0] psc_mask;
	logic overflow_flag;
	logic xtal_s1;
	logic xtal_s2;
	logic xtal_s3;
	logic osc_edge;
	logic src_event;
	logic tick;
	logic access;
	logic wr_ctrl;
	logic wr_lo;
	logic wr_hi;
	logic wr_stat;
	logic cnt_write;
	logic mapped;
	logic [31:0] next_rdata;

	assign req = '{sel: psel_i, enable: penable_i, write: pwrite_i,
		addr: paddr_i, wdata: pwdata_i};

	// Write takes effect in the access cycle in which pready is high
	assign access = req.sel && req.enable && pready_o;
	assign wr_ctrl = access && req.write && req.addr == `TPS_OFS_CTRL;
	assign wr_lo = access && req.write && req.addr == `TPS_OFS_CNT_LO;
	assign wr_hi = access && req.write && req.addr == `TPS_OFS_CNT_HI;
	assign wr_stat = access && req.write && req.addr == `TPS_OFS_STATUS;
	assign cnt_write = wr_lo || wr_hi;

	assign mapped = req.addr == `TPS_OFS_CTRL || req.addr == `TPS_OFS_CNT_LO ||
		req.addr == `TPS_OFS_CNT_HI || req.addr == `TPS_OFS_STATUS;

	// Read mux; prescale counter has no address
	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (req.addr)
			`TPS_OFS_CTRL: next_rdata[7:0] = timer_control_reg; // see (R2)
			`TPS_OFS_CNT_LO: next_rdata[7:0] = count[7:0]; // see (R8)
			`TPS_OFS_CNT_HI: next_rdata[7:0] = count[15:8]; // see (R8)
			`TPS_OFS_STATUS: next_rdata[`TPS_STAT_OVF_BIT] = overflow_flag;
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// One wait-free access cycle: answer prepared during setup
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
		end else if (req.sel && !req.enable) begin
			pready_o <= 1'b1;
			pslverr_o <= !mapped;
			prdata_o <= req.write ? 32'h0000_0000 : next_rdata;
		end else begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
		end
	end

	// Control register
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			timer_control_reg <= `TPS_CTRL_RST;
		end else if (wr_ctrl) begin
			timer_control_reg <= req.wdata[7:0] & `TPS_CTRL_WMASK;
		end
	end

	// Oscillator enable ignores sleep_i on purpose
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			crystal_amp_en_o <= 1'b0;
		end else begin
			crystal_amp_en_o <= timer_control_reg.sec_osc_enable; // see (R4) see (R5)
		end
	end

	// Crystal clock synchroniser and rising edge detect
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			xtal_s1 <= 1'b0;
			xtal_s2 <= 1'b0;
			xtal_s3 <= 1'b0;
		end else begin
			xtal_s1 <= crystal_in_pin_i;
			xtal_s2 <= xtal_s1;
			xtal_s3 <= xtal_s2;
		end
	end

	assign osc_edge = xtal_s2 && !xtal_s3 && crystal_amp_en_o;

	assign src_event = timer_control_reg.run &&
		(tps_pkg::tps_src_t'(timer_control_reg.src_sel) == tps_pkg::TPS_SRC_SEC_OSC ?
		osc_edge : 1'b1);

	// Divide ratio as a mask on the low prescaler bits
	always_comb begin
		unique case (timer_control_reg.prescale_select)
			2'h0: psc_mask = 3'h0;
			2'h1: psc_mask = 3'h1;
			2'h2: psc_mask = 3'h3;
			2'h3: psc_mask = 3'h7;
		endcase
	end

	assign tick = src_event && !cnt_write && (psc & psc_mask) == psc_mask; // see (R1)

	// Hidden prescale counter
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			psc <= `TPS_PSC_RST;
		end else if (cnt_write) begin
			psc <= `TPS_PSC_RST; // see (R3)
		end else if (src_event) begin
			psc <= (psc & psc_mask) == psc_mask ? `TPS_PSC_RST : psc + 3'h1; // see (R1)
		end
	end

	// Counter pair; a byte write wins over a tick
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			count <= `TPS_CNT_RST;
		end else if (wr_lo) begin
			count[7:0] <= req.wdata[7:0]; // see (R8)
		end else if (wr_hi) begin
			count[15:8] <= req.wdata[7:0]; // see (R8)
		end else if (tick) begin
			count <= count + 16'h0001; // see (R9)
		end
	end

	// Overflow flag, write one to clear; set wins
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			overflow_flag <= 1'b0;
		end else if (tick && count == `TPS_CNT_MAX) begin
			overflow_flag <= 1'b1; // see (R6)
		end else if (wr_stat && req.wdata[`TPS_STAT_OVF_BIT]) begin
			overflow_flag <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			overflow_flag_o <= 1'b0;
		end else begin
			overflow_flag_o <= overflow_flag;
		end
	end

	// Checks
	sequence s_byte_write;
		cnt_write;
	endsequence

	sequence s_wrap_tick;
		tick && count == `TPS_CNT_MAX;
	endsequence

	a_div_ratio_eight: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // see (R1)
		tick && timer_control_reg.prescale_select == 2'h3 |-> psc == 3'h7)
		else $error("tick under divide by eight before seventh prescale count");

	a_div_ratio_two: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // see (R1)
		tick && timer_control_reg.prescale_select == 2'h1 |-> psc[0] == 1'b1)
		else $error("tick under divide by two on wrong prescale phase");

	a_psc_write_clear: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // see (R3)
		s_byte_write |=> psc == 3'h0)
		else $error("prescaler not cleared by count write");

	a_read_hides_psc: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // see (R2)
		req.sel && !req.enable && !req.write |=> prdata_o[31:8] == 24'h000000)
		else $error("read data exposes bits above a byte");

	a_osc_enable_follow: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // see (R4)
		##1 crystal_amp_en_o == $past(timer_control_reg.sec_osc_enable))
		else $error("oscillator enable does not follow control bit");

	a_osc_sleep_hold: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // see (R5)
		sleep_i && timer_control_reg.sec_osc_enable |=> crystal_amp_en_o)
		else $error("oscillator stopped during sleep");

	a_ovf_on_wrap: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // see (R6)
		s_wrap_tick |=> overflow_flag && count == 16'h0000 ##1 overflow_flag_o)
		else $error("rollover did not raise overflow flag");

	a_ovf_no_false: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // see (R6)
		!overflow_flag && !(tick && count == `TPS_CNT_MAX) |=> !overflow_flag)
		else $error("overflow flag set without rollover");

	a_count_step_one: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // see (R9)
		tick |=> count == $past(count) + 16'h0001)
		else $error("counter did not step by one on tick");

	a_low_byte_write: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // see (R8)
		wr_lo |=> count[7:0] == $past(req.wdata[7:0]) && count[15:8] == $past(count[15:8]))
		else $error("low byte write disturbed count");

	a_high_byte_write: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // see (R8)
		wr_hi |=> count[15:8] == $past(req.wdata[7:0]) && count[7:0] == $past(count[7:0]))
		else $error("high byte write disturbed count");

	a_apb_one_access: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		psel_i && !penable_i |=> pready_o ##1 !pready_o)
		else $error("apb answer not exactly one cycle");

	sequence s_unmapped_setup;
		psel_i && !penable_i && !mapped;
	endsequence

	a_apb_err_unmapped: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		s_unmapped_setup |=> pready_o && pslverr_o)
		else $error("unmapped access without error answer");

	a_apb_err_mapped: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		psel_i && !penable_i && mapped |=> pready_o && !pslverr_o)
		else $error("mapped access answered with error");

	a_apb_idle_quiet: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		!(psel_i && !penable_i) |=> !pready_o && !pslverr_o)
		else $error("apb answer without setup cycle");

	a_rdata_idle_zero: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		!pready_o |-> prdata_o == 32'h0000_0000)
		else $error("read data outside access cycle");

	a_pready_single: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		pready_o |=> !pready_o)
		else $error("pready held past one cycle");

	a_wr_ignored_unmapped: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		access && req.write && !mapped |=> $stable(timer_control_reg))
		else $error("unmapped write changed control");

	a_ctrl_rsvd_zero: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		timer_control_reg.spare == 2'h0 && timer_control_reg.rsvd == 1'b0)
		else $error("reserved control bits set");

	a_ps_field_write: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // see (R1)
		wr_ctrl |=> timer_control_reg.prescale_select ==
		$past(req.wdata[`TPS_CTRL_PS_MSB:`TPS_CTRL_PS_LSB]))
		else $error("prescale field not taken from write");

	a_div_ratio_four: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // see (R1)
		tick && timer_control_reg.prescale_select == 2'h2 |-> psc[1:0] == 2'h3)
		else $error("tick under divide by four on wrong prescale phase");

	a_div_ratio_one: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // see (R1)
		timer_control_reg.prescale_select == 2'h0 && src_event && !cnt_write |-> tick)
		else $error("divide by one skipped a clock event");

	a_psc_hold_idle: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // see (R1)
		!src_event && !cnt_write |=> $stable(psc))
		else $error("prescaler moved without clock event");

	a_tick_drop_write: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // see (R3)
		cnt_write |-> !tick)
		else $error("tick counted during count byte write");

	a_count_hold_stop: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // see (R9)
		!timer_control_reg.run && !cnt_write |=> $stable(count))
		else $error("counter moved while stopped");

	a_osc_off_quiet: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // see (R4)
		timer_control_reg.src_sel == 1'b1 && !crystal_amp_en_o |-> !tick)
		else $error("crystal source counted with oscillator off");

	a_flag_hold_set: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // see (R6)
		overflow_flag && !(wr_stat && req.wdata[`TPS_STAT_OVF_BIT]) |=> overflow_flag)
		else $error("overflow flag dropped without clear");

	a_flag_clear_one: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // see (R6)
		wr_stat && req.wdata[`TPS_STAT_OVF_BIT] && !(tick && count == `TPS_CNT_MAX)
		|=> !overflow_flag)
		else $error("overflow flag not cleared by write one");

	a_flag_out_copy: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // see (R6)
		overflow_flag_o == $past(overflow_flag))
		else $error("overflow output does not follow flag");

endmodule
`default_nettype wire

/* File: tps_map.svh */
// Register map, field positions, reset values and counter maximum of the timer prescaler
//
// Contract
// (R1) Divide timer clock by 1, 2, 4, 8
// (R2) Prescale counter never visible to software
// (R3) Any count byte write clears prescaler
// (R4) Oscillator enabled only while enable bit set
// (R5) Oscillator keeps running during sleep
// (R6) Rollover sets overflow flag; FC00h gives 1024
// (R7) Software waits oscillator start-up before use
// (R8) 16-bit counter as two 8-bit registers
// (R9) Counter increments per prescaler tick, wrapping
`ifndef TPS_MAP_SVH
`define TPS_MAP_SVH

// Byte addresses on the APB bus
`define TPS_OFS_CTRL 12'h000
`define TPS_OFS_CNT_LO 12'h004
`define TPS_OFS_CNT_HI 12'h008
`define TPS_OFS_STATUS 12'h00c

// Control register fields
`define TPS_CTRL_RUN_BIT 0
`define TPS_CTRL_SRC_BIT 1
`define TPS_CTRL_OSC_BIT 3
`define TPS_CTRL_PS_LSB 4
`define TPS_CTRL_PS_MSB 5
`define TPS_CTRL_RST 8'h00
`define TPS_CTRL_WMASK 8'h3b

// Status register fields
`define TPS_STAT_OVF_BIT 0

// Reset values and counter maximum
`define TPS_CNT_RST 16'h0000
`define TPS_PSC_RST 3'h0
`define TPS_CNT_MAX 16'hffff

`endif

/* File: tps_pkg.sv */
// Types shared by the timer prescaler block
`default_nettype none
package tps_pkg;

	// Control register layout
	typedef struct packed {
		logic [1:0] spare;
		logic [1:0] prescale_select;
		logic sec_osc_enable;
		logic rsvd;
		logic src_sel;
		logic run;
	} tps_ctrl_t;

	// Timer clock source choice
	typedef enum logic {
		TPS_SRC_CORE = 1'b0,
		TPS_SRC_SEC_OSC = 1'b1
	} tps_src_t;

	// APB request as seen by the slave
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [11:0] addr;
		logic [31:0] wdata;
	} tps_apb_req_t;

endpackage
`default_nettype wire

/* File: tps_xtal_model.sv */
// Crystal partner model: oscillates only while its amplifier is enabled
`default_nettype none
module tps_xtal_model #(parameter int HALF = 3) (
	input wire logic clk_i,
	input wire logic amp_en_i,
	output logic xtal_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	initial xtal_o = 1'b0;
	// Stands still low while disabled, keeps running whatever the core does
	always @(posedge clk_i) begin
		if (!amp_en_i) begin
			cnt <= 0;
			xtal_o <= 1'b0;
		end else if (cnt == HALF - 1) begin
			cnt <= 0;
			xtal_o <= !xtal_o;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the timer prescaler block
`include "tps_map.svh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, sleep = 0;
	logic [11:0] addr = 12'h000;
	logic [31:0] wdat = 32'h0, prdata, rdat, p;
	logic pready, pslverr, rerr, xtal, amp_en, ovf;
	int n_fail = 0, n_compared = 0, cyc = 0;
	tps_timer tps_timer_inst (.core_clk_i(clk), .arst_n_i(rst_n), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wdat), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .sleep_i(sleep), .crystal_in_pin_i(xtal),
		.crystal_amp_en_o(amp_en), .overflow_flag_o(ovf));
	tps_xtal_model tps_xtal_model_inst (.clk_i(clk), .amp_en_i(amp_en), .xtal_o(xtal));
	initial forever #2 clk = ~clk;
	task automatic finish_test();
		if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			n_fail++;
			finish_test();
		end
	end
	task automatic chk(input logic ok, input string m);
		n_compared++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		addr <= a;
		wdat <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic waitflag(output int c);
		c = 0;
		while (ovf !== 1'b1 && c < 8000) begin
			@(posedge clk);
			c++;
		end
	endtask
	task automatic t_reset();
		for (int i = 0; i < 5; i++) begin
			rd(12'(4 * i));
			chk(rdat === 32'h0 && rerr === (i == 4), "reset read");
		end
		chk(amp_en === 1'b0 && ovf === 1'b0, "reset outputs");
		wr(12'h010, 8'hff);
		chk(rerr === 1'b1, "unmapped write not refused");
		rd(`TPS_OFS_CTRL);
		chk(rdat === 32'h0, "unmapped write landed");
		wr(`TPS_OFS_CTRL, 8'hf6);
		rd(`TPS_OFS_CTRL);
		chk(rdat === 32'h32, "control readback");
	endtask
	task automatic t_prescale();
		int e;
		for (int ps = 0; ps < 4; ps++) begin
			wr(`TPS_OFS_CTRL, 8'h00);
			wr(`TPS_OFS_CNT_HI, 8'h00);
			wr(`TPS_OFS_CNT_LO, 8'h00);
			wr(`TPS_OFS_CTRL, 8'h01 | 8'(ps << 4));
			repeat (64) @(posedge clk);
			wr(`TPS_OFS_CTRL, 8'h00);
			rd(`TPS_OFS_CNT_LO);
			e = 67 >> ps;
			chk(rdat[7:0] >= 8'(e - 1) && rdat[7:0] <= 8'(e + 1), "ratio");
		end
		wr(`TPS_OFS_CNT_LO, 8'h00);
		wr(`TPS_OFS_CTRL, 8'h31);
		repeat (20) wr(`TPS_OFS_CNT_HI, 8'h00);
		wr(`TPS_OFS_CTRL, 8'h00);
		rd(`TPS_OFS_CNT_LO);
		chk(rdat === 32'h0, "byte write keeps prescaler clear");
	endtask
	task automatic t_overflow();
		int c;
		wr(`TPS_OFS_STATUS, 8'h01);
		wr(`TPS_OFS_CNT_HI, 8'hfc);
		wr(`TPS_OFS_CNT_LO, 8'h00);
		wr(`TPS_OFS_CTRL, 8'h01);
		waitflag(c);
		chk(c >= 1022 && c <= 1028, "overflow delay");
		wr(`TPS_OFS_CTRL, 8'h00);
		rd(`TPS_OFS_CNT_HI);
		chk(rdat === 32'h0, "wrap to zero");
		rd(`TPS_OFS_STATUS);
		chk(rdat === 32'h1, "status set");
		wr(`TPS_OFS_STATUS, 8'h01);
		repeat (3) @(posedge clk);
		chk(ovf === 1'b0, "flag cleared");
	endtask
	task automatic t_osc();
		int c;
		sleep <= 1'b1;
		wr(`TPS_OFS_CTRL, 8'h08);
		repeat (3) @(posedge clk);
		chk(amp_en === 1'b1, "osc on in sleep");
		wr(`TPS_OFS_STATUS, 8'h01);
		wr(`TPS_OFS_CNT_HI, 8'hfc);
		wr(`TPS_OFS_CNT_LO, 8'h00);
		wr(`TPS_OFS_CTRL, 8'h0b);
		waitflag(c);
		chk(c >= 6130 && c <= 6160, "crystal count");
		wr(`TPS_OFS_CTRL, 8'h03);
		repeat (3) @(posedge clk);
		rd(`TPS_OFS_CNT_LO);
		p = rdat;
		repeat (30) @(posedge clk);
		rd(`TPS_OFS_CNT_LO);
		chk(rdat === p && amp_en === 1'b0, "osc off stops count");
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_prescale();
		t_overflow();
		t_osc();
		finish_test();
	end
endmodule
`default_nettype wire
